// >>> eqc_regbank.sv
// What this block does
// R1: Two-step off: wait full relock period, then check instantaneous lock.
// R2: Two-step on (reset one): wait half period, then check for errors half period.
// R3: Any enabled error in second half-step abandons setting and advances at once.
// R4: Waiting period comes from relock time field of equalizer test register.
// R5: Nesting bit: 0 equalizer inner, filter outer; 1 reverses them.
// R6: Filter inclusion bit (reset zero) adds filter delay adaption to search.
// R7: Eight-bit read-write error limit, reset one, compared against error count.
// R8: Software must never write zero into the error limit.
// R9: Physical port field bits 7:6 reads zero over local I2C.
// R10: Over back channel, physical port field returns arriving receive port.
// R11: Read-port select bit 4 routes paged reads to port 0 or 1.
// R12: Read-port select defaults to 0 for local I2C accesses.
// R13: Read-port select defaults to arriving port for back channel accesses.
// R14: Accumulate enabled errors over half period; above limit, raise equalizer setting.
// R15: Three-bit error source mask, reset all ones, enables clock, sequence, parity.
// R16: Read-port select change applies to the very next register read.
`timescale 1ns/100ps
`default_nettype none
`include "eqc_params.svh"

module eqc_regbank (
   input  wire logic       core_clk_i,        // Core clock, 125 MHz
   input  wire logic       rst_i,             // Synchronous reset, active high
   input  wire logic [7:0] reg_addr_i,        // Register address
   input  wire logic       reg_wr_i,          // Write strobe
   input  wire logic [7:0] reg_wdata_i,       // Write data
   input  wire logic       reg_rd_i,          // Read strobe
   input  wire logic       reg_src_bcc_i,     // Access arrived over back channel
   input  wire logic       reg_rx_port_i,     // Receive port of a back channel access
   input  wire logic [7:0] page0_rdata_i,     // Read data of port 0 paged block
   input  wire logic [7:0] page1_rdata_i,     // Read data of port 1 paged block
   input  wire logic [2:0] eq_relock_period_i,// Relock time field of test register
   input  wire logic       adapt_start_i,     // Request to run adaption
   input  wire logic       lock_i,            // Receiver lock, asynchronous
   input  wire logic [2:0] link_err_i,        // Error pulses: clock, sequence, parity
   output logic [7:0]      reg_rdata_o,       // Read data
   output logic            reg_rvalid_o,      // Read data valid pulse
   output logic            read_port_sel_o,   // Local read-port select
   output logic [3:0]      eq_setting_o,      // Equalizer setting
   output logic [3:0]      filter_setting_o,  // Sampling filter setting
   output logic            adapt_done_o       // Adaption settled
);

   // Register state
   logic [2:0] eq_error_source_mask_r;
   logic [2:0] eq_error_source_mask_nxt;
   logic       filt_order_r;
   logic       filt_order_nxt;
   logic       two_step_check_enable_r;
   logic       two_step_check_enable_nxt;
   logic       loop_nesting_select_r;
   logic       loop_nesting_select_nxt;
   logic       filter_in_eq_enable_r;
   logic       filter_in_eq_enable_nxt;
   logic [7:0] eq_error_limit_value_r;
   logic [7:0] eq_error_limit_value_nxt;
   logic       local_sel_r;
   logic       local_sel_nxt;
   logic [1:0] bcc_sel_r;
   logic [1:0] bcc_sel_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       rvalid_r;
   logic       rvalid_nxt;

   logic       wr_ctl;
   logic       wr_limit;
   logic       wr_sel;
   logic       eff_sel;
   logic [1:0] phys_port;
   logic [7:0] rd_mux;

   assign wr_ctl   = reg_wr_i && (reg_addr_i == `EQC_ADDR_CONTROL);
   assign wr_limit = reg_wr_i && (reg_addr_i == `EQC_ADDR_LIMIT);
   assign wr_sel   = reg_wr_i && (reg_addr_i == `EQC_ADDR_PORT_SEL);

   // Each back channel port keeps its own select, reset to its own index
   genvar gp;
   generate
      for (gp = 0; gp < 2; gp++) begin : g_bcc_sel
         always_comb begin
            bcc_sel_nxt[gp] = bcc_sel_r[gp];
            if (wr_sel && reg_src_bcc_i && (reg_rx_port_i == 1'(gp))) begin
               bcc_sel_nxt[gp] = reg_wdata_i[`EQC_SEL_READ_BIT];
            end
         end
      end
   endgenerate

   always_comb begin
      eq_error_source_mask_nxt  = eq_error_source_mask_r;
      filt_order_nxt            = filt_order_r;
      two_step_check_enable_nxt = two_step_check_enable_r;
      loop_nesting_select_nxt   = loop_nesting_select_r;
      filter_in_eq_enable_nxt   = filter_in_eq_enable_r;
      eq_error_limit_value_nxt  = eq_error_limit_value_r;
      local_sel_nxt             = local_sel_r;
      if (wr_ctl) begin
         eq_error_source_mask_nxt  = reg_wdata_i[`EQC_CTL_MASK_HI:`EQC_CTL_MASK_LO]; // R15
         filt_order_nxt            = reg_wdata_i[`EQC_CTL_ORDER_BIT];
         two_step_check_enable_nxt = reg_wdata_i[`EQC_CTL_TWO_STEP_BIT];
         loop_nesting_select_nxt   = reg_wdata_i[`EQC_CTL_NEST_BIT];
         filter_in_eq_enable_nxt   = reg_wdata_i[`EQC_CTL_FILT_BIT];
      end
      if (wr_limit) begin
         eq_error_limit_value_nxt = reg_wdata_i; // R7 R8
      end
      if (wr_sel && !reg_src_bcc_i) begin
         local_sel_nxt = reg_wdata_i[`EQC_SEL_READ_BIT];
      end
   end

   // Read path: select and physical port follow the source of this access
   always_comb begin
      eff_sel   = reg_src_bcc_i ? bcc_sel_r[reg_rx_port_i] : local_sel_r; // R12 R13
      phys_port = reg_src_bcc_i ? {1'b0, reg_rx_port_i} : 2'h0;           // R9 R10
      case (reg_addr_i)
         `EQC_ADDR_CONTROL: begin
            rd_mux = {1'b0, eq_error_source_mask_r, filt_order_r,
                      two_step_check_enable_r, loop_nesting_select_r,
                      filter_in_eq_enable_r};
         end
         `EQC_ADDR_LIMIT: begin
            rd_mux = eq_error_limit_value_r;
         end
         `EQC_ADDR_PORT_SEL: begin
            rd_mux = {phys_port, 1'b0, eff_sel, 4'h0};
         end
         default: begin
            if (reg_addr_i >= `EQC_ADDR_RSVD_FIRST && reg_addr_i <= `EQC_ADDR_RSVD_LAST) begin
               rd_mux = 8'h00;
            end else begin
               rd_mux = eff_sel ? page1_rdata_i : page0_rdata_i; // R11 R16
            end
         end
      endcase
      rdata_nxt  = reg_rd_i ? rd_mux : rdata_r;
      rvalid_nxt = reg_rd_i;
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         eq_error_source_mask_r  <= `EQC_RST_MASK;
         filt_order_r            <= `EQC_RST_ORDER;
         two_step_check_enable_r <= `EQC_RST_TWO_STEP;
         loop_nesting_select_r   <= `EQC_RST_NEST;
         filter_in_eq_enable_r   <= `EQC_RST_FILT;
         eq_error_limit_value_r  <= `EQC_RST_LIMIT;
         local_sel_r             <= `EQC_RST_LOCAL_SEL;
         bcc_sel_r               <= 2'h2;
         rdata_r                 <= 8'h00;
         rvalid_r                <= 1'b0;
      end else begin
         eq_error_source_mask_r  <= eq_error_source_mask_nxt;
         filt_order_r            <= filt_order_nxt;
         two_step_check_enable_r <= two_step_check_enable_nxt;
         loop_nesting_select_r   <= loop_nesting_select_nxt;
         filter_in_eq_enable_r   <= filter_in_eq_enable_nxt;
         eq_error_limit_value_r  <= eq_error_limit_value_nxt;
         local_sel_r             <= local_sel_nxt;
         bcc_sel_r               <= bcc_sel_nxt;
         rdata_r                 <= rdata_nxt;
         rvalid_r                <= rvalid_nxt;
      end
   end

   // Equalizer search sequencer
   logic lock_sync;

   eqc_sync2 u_lock_sync (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .async_i    (lock_i),
      .sync_o     (lock_sync)
   );

   eqc_pkg::eqc_state_type state_r;
   eqc_pkg::eqc_state_type state_nxt;
   logic [11:0] timer_r;
   logic [11:0] timer_nxt;
   logic [8:0]  err_cnt_r;
   logic [8:0]  err_cnt_nxt;
   logic [3:0]  eq_r;
   logic [3:0]  eq_nxt;
   logic [3:0]  filt_r;
   logic [3:0]  filt_nxt;
   logic        done_r;
   logic        done_nxt;

   logic [11:0] full_cycles;
   logic [11:0] half_cycles;
   logic        err_seen;
   logic [3:0]  adv_eq;
   logic [3:0]  adv_filt;

   // Period = (field + 1) relock units
   assign full_cycles = 12'((({9'h000, eq_relock_period_i}) + 12'h001)
                            * 12'(`EQC_RELOCK_UNIT_CYC));                 // R4
   assign half_cycles = {1'b0, full_cycles[11:1]};
   assign err_seen    = |(link_err_i & eq_error_source_mask_r);           // R15

   // Next candidate; nesting decides which setting steps fastest
   always_comb begin
      adv_eq   = eq_r;
      adv_filt = filt_r;
      if (!filter_in_eq_enable_r) begin                                  // R6
         adv_eq = (eq_r == `EQC_EQ_MAX) ? 4'h0 : 4'(eq_r + 4'h1);
      end else if (!loop_nesting_select_r) begin                         // R5
         if (eq_r == `EQC_EQ_MAX) begin
            adv_eq   = 4'h0;
            adv_filt = (filt_r == `EQC_FILT_MAX) ? 4'h0 : 4'(filt_r + 4'h1);
         end else begin
            adv_eq = 4'(eq_r + 4'h1);
         end
      end else begin
         if (filt_r == `EQC_FILT_MAX) begin
            adv_filt = 4'h0;
            adv_eq   = (eq_r == `EQC_EQ_MAX) ? 4'h0 : 4'(eq_r + 4'h1);
         end else begin
            adv_filt = 4'(filt_r + 4'h1);
         end
      end
   end

   always_comb begin
      state_nxt   = state_r;
      timer_nxt   = timer_r;
      err_cnt_nxt = err_cnt_r;
      eq_nxt      = eq_r;
      filt_nxt    = filt_r;
      done_nxt    = done_r;
      case (state_r)
         eqc_pkg::EQC_IDLE: begin
            if (adapt_start_i) begin
               eq_nxt    = 4'h0;
               filt_nxt  = filter_in_eq_enable_r ?
                           (filt_order_r ? `EQC_FILT_MID : 4'h0) : `EQC_FILT_MID;
               done_nxt  = 1'b0;
               state_nxt = eqc_pkg::EQC_APPLY;
            end
         end
         eqc_pkg::EQC_APPLY: begin
            timer_nxt   = two_step_check_enable_r ? half_cycles : full_cycles; // R1 R2
            err_cnt_nxt = 9'h000;
            state_nxt   = eqc_pkg::EQC_SETTLE;
         end
         eqc_pkg::EQC_SETTLE: begin
            if (timer_r > 12'h001) begin
               timer_nxt = 12'(timer_r - 12'h001);
            end else if (two_step_check_enable_r) begin
               timer_nxt = half_cycles;                                   // R2
               state_nxt = eqc_pkg::EQC_CHECK;
            end else if (lock_sync) begin                                 // R1
               done_nxt  = 1'b1;
               timer_nxt = half_cycles;
               state_nxt = eqc_pkg::EQC_MONITOR;
            end else begin
               eq_nxt    = adv_eq;
               filt_nxt  = adv_filt;
               state_nxt = eqc_pkg::EQC_APPLY;
            end
         end
         eqc_pkg::EQC_CHECK: begin
            if (err_seen) begin                                           // R3
               eq_nxt    = adv_eq;
               filt_nxt  = adv_filt;
               state_nxt = eqc_pkg::EQC_APPLY;
            end else if (timer_r > 12'h001) begin
               timer_nxt = 12'(timer_r - 12'h001);
            end else begin
               done_nxt    = 1'b1;
               timer_nxt   = half_cycles;
               err_cnt_nxt = 9'h000;
               state_nxt   = eqc_pkg::EQC_MONITOR;
            end
         end
         eqc_pkg::EQC_MONITOR: begin
            if (adapt_start_i) begin
               state_nxt = eqc_pkg::EQC_IDLE;
            end else if (timer_r > 12'h001) begin
               timer_nxt = 12'(timer_r - 12'h001);
               if (err_seen && err_cnt_r != 9'h1FF) begin                 // R14
                  err_cnt_nxt = 9'(err_cnt_r + 9'h001);
               end
            end else if (err_cnt_r > {1'b0, eq_error_limit_value_r}) begin // R7 R14
               eq_nxt    = (eq_r == `EQC_EQ_MAX) ? eq_r : 4'(eq_r + 4'h1);
               done_nxt  = 1'b0;
               state_nxt = eqc_pkg::EQC_APPLY;
            end else begin
               timer_nxt   = half_cycles;
               err_cnt_nxt = 9'h000;
            end
         end
         default: begin
            state_nxt = eqc_pkg::EQC_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_r   <= eqc_pkg::EQC_IDLE;
         timer_r   <= 12'h000;
         err_cnt_r <= 9'h000;
         eq_r      <= 4'h0;
         filt_r    <= `EQC_FILT_MID;
         done_r    <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         timer_r   <= timer_nxt;
         err_cnt_r <= err_cnt_nxt;
         eq_r      <= eq_nxt;
         filt_r    <= filt_nxt;
         done_r    <= done_nxt;
      end
   end

   assign reg_rdata_o      = rdata_r;
   assign reg_rvalid_o     = rvalid_r;
   assign read_port_sel_o  = local_sel_r;
   assign eq_setting_o     = eq_r;
   assign filter_setting_o = filt_r;
   assign adapt_done_o     = done_r;

endmodule

`default_nettype wire

// >>> eqc_params.svh
`ifndef EQC_PARAMS_SVH
`define EQC_PARAMS_SVH

// Register offsets
`define EQC_ADDR_CONTROL      8'h42
`define EQC_ADDR_LIMIT        8'h43
`define EQC_ADDR_RSVD_FIRST   8'h44
`define EQC_ADDR_RSVD_LAST    8'h4B
`define EQC_ADDR_PORT_SEL     8'h4C

// eq_control field positions
`define EQC_CTL_MASK_HI       6
`define EQC_CTL_MASK_LO       4
`define EQC_CTL_ORDER_BIT     3
`define EQC_CTL_TWO_STEP_BIT  2
`define EQC_CTL_NEST_BIT      1
`define EQC_CTL_FILT_BIT      0

// port_page_select field positions
`define EQC_SEL_PHYS_HI       7
`define EQC_SEL_PHYS_LO       6
`define EQC_SEL_READ_BIT      4

// Reset values
`define EQC_RST_MASK          3'h7
`define EQC_RST_ORDER         1'h0
`define EQC_RST_TWO_STEP      1'h1
`define EQC_RST_NEST          1'h0
`define EQC_RST_FILT          1'h0
`define EQC_RST_LIMIT         8'h01
`define EQC_RST_LOCAL_SEL     1'h0

// Setting ranges
`define EQC_EQ_MAX            4'hF
`define EQC_FILT_MAX          4'hE
`define EQC_FILT_MID          4'h7

// Timing
`define EQC_CLK_PERIOD_NS     8
`define EQC_RELOCK_UNIT_NS    1000
`define EQC_RELOCK_UNIT_CYC   ((`EQC_RELOCK_UNIT_NS + `EQC_CLK_PERIOD_NS - 1) / `EQC_CLK_PERIOD_NS)

`endif

// >>> eqc_pkg.sv
`default_nettype none

package eqc_pkg;

   typedef enum logic [4:0] {
      EQC_IDLE    = 5'h01,
      EQC_APPLY   = 5'h02,
      EQC_SETTLE  = 5'h04,
      EQC_CHECK   = 5'h08,
      EQC_MONITOR = 5'h10
   } eqc_state_type;

endpackage

`default_nettype wire

// >>> eqc_sync2.sv
`timescale 1ns/100ps
`default_nettype none

module eqc_sync2 (
   input  wire logic core_clk_i,   // Core clock
   input  wire logic rst_i,        // Synchronous reset, active high
   input  wire logic async_i,      // Level from another domain
   output logic      sync_o        // Level in core domain
);

   logic meta_r;
   logic meta_nxt;
   logic sync_r;
   logic sync_nxt;

   always_comb begin
      meta_nxt = async_i;
      sync_nxt = meta_r;
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign sync_o = sync_r;

endmodule

`default_nettype wire

// >>> eqc_page_model.sv
`timescale 1ns/100ps
`default_nettype none

module eqc_page_model (
   input  wire logic [7:0] reg_addr_i,    // Address of the paged access
   output logic      [7:0] page0_rdata_o, // Port 0 block read data
   output logic      [7:0] page1_rdata_o  // Port 1 block read data
);
   // Distinct patterns per block so a wrong route shows at once
   assign page0_rdata_o = reg_addr_i ^ 8'h3C;
   assign page1_rdata_o = ~reg_addr_i;
endmodule

`default_nettype wire

// >>> eqc_regbank_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "eqc_params.svh"

module eqc_regbank_monitor (
   input wire logic       core_clk_i,      // Core clock
   input wire logic       rst_i,           // Synchronous reset
   input wire logic [7:0] reg_addr_i,      // Register address
   input wire logic       reg_wr_i,        // Write strobe
   input wire logic [7:0] reg_wdata_i,     // Write data
   input wire logic       reg_rd_i,        // Read strobe
   input wire logic       reg_src_bcc_i,   // Back channel access
   input wire logic       reg_rx_port_i,   // Arriving receive port
   input wire logic [7:0] page0_rdata_i,   // Port 0 block data
   input wire logic [7:0] page1_rdata_i,   // Port 1 block data
   input wire logic [7:0] reg_rdata_o,     // Read data
   input wire logic       reg_rvalid_o,    // Read valid
   input wire logic       read_port_sel_o, // Local read-port select
   input wire logic [3:0] eq_setting_o,    // Equalizer setting
   input wire logic [3:0] filter_setting_o,// Filter setting
   input wire logic       adapt_done_o     // Adaption settled
);
   default clocking mon_cb @(posedge core_clk_i);
   endclocking

   logic paged_c;
   logic sel_wr_c;
   assign paged_c = reg_addr_i < `EQC_ADDR_CONTROL || reg_addr_i > `EQC_ADDR_PORT_SEL;
   assign sel_wr_c = reg_wr_i && !reg_src_bcc_i && reg_addr_i == `EQC_ADDR_PORT_SEL;

   sequence limit_write;
      reg_wr_i && reg_addr_i == `EQC_ADDR_LIMIT;
   endsequence
   sequence limit_read;
      reg_rd_i && reg_addr_i == `EQC_ADDR_LIMIT;
   endsequence

   chk_rvalid_pulse: assert property (disable iff (rst_i) reg_rd_i |=> reg_rvalid_o ##1
      (reg_rvalid_o == $past(reg_rd_i))) else $error("read valid not a one cycle answer");
   chk_reset_state: assert property (rst_i |=> !reg_rvalid_o && !read_port_sel_o &&
      eq_setting_o == 4'h0 && filter_setting_o == 4'h7 && !adapt_done_o)
      else $error("outputs not at reset values");
   chk_phys_local: assert property (disable iff (rst_i) reg_rd_i && !reg_src_bcc_i &&
      reg_addr_i == `EQC_ADDR_PORT_SEL |=> reg_rdata_o[7:6] == 2'h0)
      else $error("local port field not zero");
   chk_phys_remote: assert property (disable iff (rst_i) reg_rd_i && reg_src_bcc_i &&
      reg_addr_i == `EQC_ADDR_PORT_SEL |=> reg_rdata_o[7:6] == {1'b0, $past(reg_rx_port_i)})
      else $error("remote port field wrong");
   chk_page_route: assert property (disable iff (rst_i) reg_rd_i && !reg_src_bcc_i &&
      paged_c |=> reg_rdata_o == $past(read_port_sel_o ? page1_rdata_i : page0_rdata_i))
      else $error("paged read from wrong block");
   chk_rsvd_zero: assert property (disable iff (rst_i) reg_rd_i &&
      reg_addr_i >= `EQC_ADDR_RSVD_FIRST && reg_addr_i <= `EQC_ADDR_RSVD_LAST |=>
      reg_rdata_o == 8'h00) else $error("reserved read not zero");
   chk_sel_local: assert property (disable iff (rst_i) sel_wr_c |=>
      read_port_sel_o == $past(reg_wdata_i[4])) else $error("local select not updated");
   chk_sel_hold: assert property (disable iff (rst_i) !sel_wr_c |=>
      $stable(read_port_sel_o)) else $error("local select changed without local write");
   chk_limit_rw: assert property (disable iff (rst_i) limit_write ##1 limit_read |=>
      reg_rdata_o == $past(reg_wdata_i, 2)) else $error("error limit not read back");
endmodule

`default_nettype wire

// >>> adaptive_eq_ctl_port_select_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "eqc_params.svh"

module adaptive_eq_ctl_port_select_tb_top;
   logic       core_clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic       reg_wr_i = 1'b0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic       reg_rd_i = 1'b0;
   logic       reg_src_bcc_i = 1'b0;
   logic       reg_rx_port_i = 1'b0;
   logic [7:0] page0_rdata_i;
   logic [7:0] page1_rdata_i;
   logic [2:0] eq_relock_period_i = 3'h0;
   logic       adapt_start_i = 1'b0;
   logic       lock_i = 1'b0;
   logic [2:0] link_err_i = 3'h0;
   logic [7:0] reg_rdata_o;
   logic       reg_rvalid_o;
   logic       read_port_sel_o;
   logic [3:0] eq_setting_o;
   logic [3:0] filter_setting_o;
   logic       adapt_done_o;
   int         n_mismatch = 0;
   int         cmp_count = 0;
   int         cyc = 0;
   int         i;
   logic [18:0] rows [21];
   logic [15:0] adv_rows [5];

   always #4 core_clk_i = ~core_clk_i;

   eqc_page_model u_pages (.reg_addr_i(reg_addr_i), .page0_rdata_o(page0_rdata_i),
      .page1_rdata_o(page1_rdata_i));
   eqc_regbank dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
      .reg_src_bcc_i(reg_src_bcc_i), .reg_rx_port_i(reg_rx_port_i),
      .page0_rdata_i(page0_rdata_i), .page1_rdata_i(page1_rdata_i),
      .eq_relock_period_i(eq_relock_period_i), .adapt_start_i(adapt_start_i),
      .lock_i(lock_i), .link_err_i(link_err_i), .reg_rdata_o(reg_rdata_o),
      .reg_rvalid_o(reg_rvalid_o), .read_port_sel_o(read_port_sel_o),
      .eq_setting_o(eq_setting_o), .filter_setting_o(filter_setting_o),
      .adapt_done_o(adapt_done_o));

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   task automatic expect_true(input logic c, input string m);
      cmp_count++;
      if (c !== 1'b1) begin
         n_mismatch++;
         $display("Error at %0t: %s", $time, m);
      end
   endtask

   // Called just after a rising edge; returns just after one
   // A write leaves its strobe up for the next access or start_adapt to lower
   task automatic access(input logic wr, input logic bcc, input logic port,
                         input logic [7:0] addr, input logic [7:0] data);
      reg_addr_i <= addr;
      reg_src_bcc_i <= bcc;
      reg_rx_port_i <= port;
      reg_wdata_i <= data;
      reg_wr_i <= wr;
      reg_rd_i <= !wr;
      @(posedge core_clk_i);
      if (!wr) begin
         reg_rd_i <= 1'b0;
         @(negedge core_clk_i);
         expect_true(reg_rvalid_o === 1'b1 && reg_rdata_o === data, "read data mismatch");
         @(posedge core_clk_i);
      end
   endtask

   task automatic do_reset;
      rst_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
   endtask

   task automatic start_adapt;
      reg_wr_i <= 1'b0;
      adapt_start_i <= 1'b1;
      @(posedge core_clk_i);
      adapt_start_i <= 1'b0;
   endtask

   task automatic wait_done;
      for (i = 0; i < 400 && adapt_done_o !== 1'b1; i++) @(posedge core_clk_i);
   endtask

   initial begin
      // wr, bcc, port, addr, write data or expected read data
      rows = '{{3'b000, 8'h42, 8'h74}, {3'b000, 8'h43, 8'h01}, {3'b000, 8'h4C, 8'h00},
               {3'b011, 8'h4C, 8'h50}, {3'b010, 8'h4C, 8'h00}, {3'b100, 8'h44, 8'hFF},
               {3'b000, 8'h44, 8'h00}, {3'b000, 8'h4B, 8'h00}, {3'b100, 8'h43, 8'h10},
               {3'b011, 8'h43, 8'h10}, {3'b100, 8'h42, 8'hFF}, {3'b000, 8'h42, 8'h7F},
               {3'b000, 8'h10, 8'h2C}, {3'b100, 8'h4C, 8'hFF}, {3'b000, 8'h4C, 8'h10},
               {3'b000, 8'h10, 8'hEF}, {3'b010, 8'h20, 8'h1C}, {3'b011, 8'h20, 8'hDF},
               {3'b111, 8'h4C, 8'h00}, {3'b011, 8'h20, 8'h1C}, {3'b000, 8'h20, 8'hDF}};
      // control value, expected equalizer and filter after the first advance
      adv_rows = '{16'h7417, 16'h7701, 16'h7510, 16'h7D17, 16'h7017};
      do_reset();
      expect_true(eq_setting_o === 4'h0 && filter_setting_o === 4'h7, "reset settings");
      expect_true(adapt_done_o === 1'b0 && read_port_sel_o === 1'b0, "reset flags");
      for (int k = 0; k < 21; k++)
         access(rows[k][18], rows[k][17], rows[k][16], rows[k][15:8], rows[k][7:0]);
      access(1'b1, 1'b0, 1'b0, 8'h4C, 8'h00);
      access(1'b0, 1'b0, 1'b0, 8'h10, 8'h2C);
      for (int k = 0; k < 5; k++) begin
         do_reset();
         access(1'b1, 1'b0, 1'b0, `EQC_ADDR_CONTROL, adv_rows[k][15:8]);
         start_adapt();
         link_err_i <= 3'h7;
         for (i = 0; i < 300 && eq_setting_o === 4'h0 && (filter_setting_o === 4'h0 ||
              filter_setting_o === 4'h7); i++) @(posedge core_clk_i);
         expect_true(eq_setting_o === adv_rows[k][7:4] &&
                     filter_setting_o === adv_rows[k][3:0], "advance order");
         link_err_i <= 3'h0;
      end
      do_reset();
      eq_relock_period_i <= 3'h1;
      start_adapt();
      repeat (200) @(posedge core_clk_i);
      expect_true(adapt_done_o === 1'b0, "settled before the programmed period");
      wait_done();
      expect_true(adapt_done_o === 1'b1 && eq_setting_o === 4'h0, "two-step settle");
      link_err_i <= 3'h1;
      repeat (3) @(posedge core_clk_i);
      link_err_i <= 3'h0;
      for (i = 0; i < 300 && eq_setting_o !== 4'h1; i++) @(posedge core_clk_i);
      expect_true(eq_setting_o === 4'h1, "monitor did not raise setting");
      do_reset();
      eq_relock_period_i <= 3'h0;
      lock_i <= 1'b1;
      access(1'b1, 1'b0, 1'b0, `EQC_ADDR_CONTROL, 8'h70);
      start_adapt();
      wait_done();
      expect_true(adapt_done_o === 1'b1 && eq_setting_o === 4'h0, "lock check");
      do_reset();
      access(1'b1, 1'b0, 1'b0, `EQC_ADDR_CONTROL, 8'h04);
      link_err_i <= 3'h7;
      start_adapt();
      wait_done();
      expect_true(adapt_done_o === 1'b1 && eq_setting_o === 4'h0, "masked errors");
      link_err_i <= 3'h0;
      wrap_up();
   end
endmodule

bind eqc_regbank eqc_regbank_monitor u_mon (.core_clk_i(core_clk_i), .rst_i(rst_i),
   .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
   .reg_rd_i(reg_rd_i), .reg_src_bcc_i(reg_src_bcc_i), .reg_rx_port_i(reg_rx_port_i),
   .page0_rdata_i(page0_rdata_i), .page1_rdata_i(page1_rdata_i),
   .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
   .read_port_sel_o(read_port_sel_o), .eq_setting_o(eq_setting_o),
   .filter_setting_o(filter_setting_o), .adapt_done_o(adapt_done_o));

`default_nettype wire
